// ---- include/adc_port_cfg.svh ----
// constants for the serial converter control port: config word layout,
// word length codes and the counts that pace arming, sampling and converting.
// assumes the files that include it treat every value as a sized literal.
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// configuration word, first bit shifted in lands in the highest position
`define CFG_W 8
`define CFG_MODE_BIT 7
`define CFG_ODD_BIT 6
`define CFG_SEL_HI 5
`define CFG_SEL_LO 4
`define CFG_POL_BIT 3
`define CFG_MSBF_BIT 2
`define CFG_WL_HI 1
`define CFG_WL_LO 0

// selector fields inside the shift register once four bits are in
`define MUX_MODE_POS 3
`define MUX_ODD_POS 2
`define MUX_SEL_HI 1
`define MUX_SEL_LO 0

// word length field codes; the last one requests power shutdown
`define WL_12 2'h0
`define WL_8 2'h1
`define WL_16 2'h2
`define WL_PD 2'h3

// output word lengths in bits
`define LEN_8 5'h08
`define LEN_12 5'h0C
`define LEN_16 5'h10

// result width
`define RES_W 12

// falling conversion-clock edges before the port answers
`define ARM_EDGES 2'h2
// conversion length in conversion-clock cycles
`define CONV_CYCLES 6'h34

// shift-clock bit positions within a frame
`define BIT_CNT_MAX 5'h1F
`define MUX_BITS 5'h04
`define SAMPLE_CYCLES 5'h07
`define CFG_LAST 5'h07

`endif

// ---- include/adc_port_pkg.sv ----
// types shared by the serial converter control port and its helpers.
// assumes adc_port_cfg.svh supplies the numeric constants.
package adc_port_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARM,
    ST_FRAME,
    ST_CONV,
    ST_PDOWN
  } ctrl_state_t;

  typedef logic [4:0] word_len_t;
  typedef logic [15:0] out_word_t;

endpackage : adc_port_pkg

// ---- src/sync_2ff.sv ----
// two flip-flop synchroniser for a bundle of independent level inputs.
// assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/1ns
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // destination clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic ce_i, // clock enable
  input wire logic [WIDTH-1:0] async_i, // levels from another domain
  input wire logic [WIDTH-1:0] init_i, // constant, masked to zero, has no effect
  output logic [WIDTH-1:0] sync_o // synchronised levels
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb
  begin
    meta_next = meta_reg;
    sync_next = sync_reg;
    if (ce_i)
    begin
      meta_next = async_i;
      sync_next = meta_reg;
    end
  end

  // reset takes zero; init_i is masked to zero and never reaches sync_o
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg ^ (init_i & '0);

endmodule : sync_2ff

// ---- src/result_formatter.sv ----
// turns a raw converter code into the serial output word and its length.
// assumes raw_code_i is offset binary for bipolar and straight binary otherwise.
`timescale 1ns/1ns
`include "adc_port_cfg.svh"
module result_formatter (
  input wire logic [`RES_W-1:0] raw_code_i, // code from the converter array
  input wire logic unipolar_i, // 1: unipolar, 0: bipolar
  input wire logic msb_first_i, // 1: msb leads the word
  input wire logic [1:0] wl_code_i, // word length field
  output adc_port_pkg::out_word_t word_o, // bit 0 leaves first
  output adc_port_pkg::word_len_t len_o // bits to shift out
);
  import adc_port_pkg::*;

  logic [`RES_W-1:0] coded;

  always_comb
  begin
    coded = raw_code_i;
    // bipolar: flipping the top bit of offset binary gives two's complement
    if (!unipolar_i)
    begin
      coded[`RES_W-1] = ~raw_code_i[`RES_W-1];
    end
    word_o = '0;
    for (int i = 0; i < `RES_W; i++)
    begin
      word_o[i] = msb_first_i ? coded[`RES_W-1-i] : coded[i];
    end
    case (wl_code_i)
      `WL_8: len_o = `LEN_8;
      `WL_16: len_o = `LEN_16;
      default: len_o = `LEN_12;
    endcase
  end

endmodule : result_formatter

// ---- src/adc_port_top.sv ----
// control and serial transfer logic of an eight input 12-bit sampling converter.
// assumes the analog array hands raw_code_i on core_clk_i and that sclk_i idles low;
// cs_n_i, aclk_i come from pins, din_i is timed to sclk_i.
//
// Overview of operation
// - result is 12-bit straight binary unipolar, 11-bit plus sign bipolar
// - bipolar results come out in two's complement automatically
// - host picks msb-first or lsb-first; device shifts in that order
// - host picks word length; device sends exactly 8, 12 or 16 bits
// - eight input selector: single-ended, differential pairs, or a mix
// - host may request shutdown while idle; conversion clock may then stop
// - after cs falls, control waits two falling conversion-clock edges; din is still shifted in meanwhile
// - data output enabled on second falling conversion-clock edge, high-z before
// - selected input is sampled for 7 shift-clock cycles in the frame
// - conversion takes 52 conversion-clock cycles; host keeps cs high meanwhile
// - output bit changes only after a falling shift-clock edge, or clears to zero when cs goes high
// - input bits captured on rising shift-clock edges; host keeps them stable
// - 8-bit config shifted in while previous result shifts out
// - each result comes out one chip-select frame after its request
// - first four config bits choose the channel arrangement
// - fifth config bit one means unipolar, zero means bipolar
`timescale 1ns/1ns
`include "adc_port_cfg.svh"
module adc_port_top (
  input wire logic core_clk_i, // core clock, 20 MHz
  input wire logic reset_n_i, // async reset, active low
  input wire logic ce_i, // clock enable for the core domain
  input wire logic cs_n_i, // chip select pin, active low
  input wire logic aclk_i, // conversion clock pin
  input wire logic sclk_i, // shift clock pin, link domain clock
  input wire logic din_i, // serial config data
  input wire logic [`RES_W-1:0] raw_code_i, // raw code from the array
  output logic dout_o, // serial result data
  output logic dout_oe_o, // output enable of dout pin
  output logic sample_o, // track/hold in track
  output logic [2:0] pos_ch_o, // channel on the plus side
  output logic [2:0] neg_ch_o, // channel on the minus side
  output logic neg_com_o, // minus side is common_reference_input
  output logic conv_busy_o, // conversion running
  output logic pwr_down_o, // power shutdown state
  output adc_port_pkg::ctrl_state_t state_o // control state
);
  import adc_port_pkg::*;

  // ---------------- core domain ----------------
  logic [2:0] pins_sync;
  logic cs_s;
  logic aclk_s;
  logic full_s;
  logic cs_d_reg;
  logic cs_d_next;
  logic aclk_d_reg;
  logic aclk_d_next;
  logic cs_fall;
  logic cs_rise;
  logic aclk_fall;

  logic cfg_full_reg;
  logic [`CFG_W-1:0] cfg_shift_reg;

  sync_2ff #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .async_i({cfg_full_reg, aclk_i, cs_n_i}),
    .init_i(3'h0),
    .sync_o(pins_sync)
  );

  assign cs_s = pins_sync[0];
  assign aclk_s = pins_sync[1];
  assign full_s = pins_sync[2];
  assign cs_fall = cs_d_reg & ~cs_s;
  assign cs_rise = ~cs_d_reg & cs_s;
  assign aclk_fall = aclk_d_reg & ~aclk_s;

  always_comb
  begin
    cs_d_next = cs_d_reg;
    aclk_d_next = aclk_d_reg;
    if (ce_i)
    begin
      cs_d_next = cs_s;
      aclk_d_next = aclk_s;
    end
  end

  // synchroniser resets low, so the delayed copy does too: no false fall after release
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cs_d_reg <= 1'b0;
      aclk_d_reg <= 1'b0;
    end
    else
    begin
      cs_d_reg <= cs_d_next;
      aclk_d_reg <= aclk_d_next;
    end
  end

  ctrl_state_t state_reg;
  ctrl_state_t state_next;
  logic [1:0] arm_cnt_reg;
  logic [1:0] arm_cnt_next;
  logic [5:0] conv_cnt_reg;
  logic [5:0] conv_cnt_next;
  logic full_seen_reg;
  logic full_seen_next;
  logic oe_reg;
  logic oe_next;
  logic busy_reg;
  logic busy_next;
  logic pd_reg;
  logic pd_next;
  logic uni_reg;
  logic uni_next;
  logic msbf_reg;
  logic msbf_next;
  logic [1:0] wl_reg;
  logic [1:0] wl_next;
  out_word_t out_word_reg;
  out_word_t out_word_next;
  word_len_t out_len_reg;
  word_len_t out_len_next;
  out_word_t fmt_word;
  word_len_t fmt_len;

  result_formatter u_fmt (
    .raw_code_i(raw_code_i),
    .unipolar_i(uni_reg),
    .msb_first_i(msbf_reg),
    .wl_code_i(wl_reg),
    .word_o(fmt_word),
    .len_o(fmt_len)
  );

  always_comb
  begin
    state_next = state_reg;
    arm_cnt_next = arm_cnt_reg;
    conv_cnt_next = conv_cnt_reg;
    full_seen_next = full_seen_reg;
    oe_next = oe_reg;
    busy_next = busy_reg;
    pd_next = pd_reg;
    uni_next = uni_reg;
    msbf_next = msbf_reg;
    wl_next = wl_reg;
    out_word_next = out_word_reg;
    out_len_next = out_len_reg;
    if (ce_i)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (cs_fall)
          begin
            state_next = ST_ARM;
            arm_cnt_next = 2'h0;
            full_seen_next = 1'b0;
          end
        end
        ST_ARM:
        begin
          // config bits arriving now still reach cfg_shift_reg; full_seen only picks up full_s in ST_FRAME
          if (cs_rise)
          begin
            state_next = ST_IDLE;
          end
          else if (aclk_fall)
          begin
            if (arm_cnt_reg == `ARM_EDGES - 2'h1)
            begin
              state_next = ST_FRAME;
              oe_next = 1'b1;
            end
            else
            begin
              arm_cnt_next = arm_cnt_reg + 2'h1;
            end
          end
        end
        ST_FRAME:
        begin
          if (full_s)
          begin
            full_seen_next = 1'b1;
          end
          if (cs_rise)
          begin
            oe_next = 1'b0;
            // link side is parked now, so its config word is stable
            if (full_seen_reg)
            begin
              uni_next = cfg_shift_reg[`CFG_POL_BIT];
              msbf_next = cfg_shift_reg[`CFG_MSBF_BIT];
              wl_next = cfg_shift_reg[`CFG_WL_HI:`CFG_WL_LO];
              if (cfg_shift_reg[`CFG_WL_HI:`CFG_WL_LO] == `WL_PD)
              begin
                state_next = ST_PDOWN;
                pd_next = 1'b1;
              end
              else
              begin
                state_next = ST_CONV;
                busy_next = 1'b1;
                conv_cnt_next = 6'h00;
              end
            end
            else
            begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_CONV:
        begin
          if (aclk_fall)
          begin
            if (conv_cnt_reg == `CONV_CYCLES - 6'h01)
            begin
              // held for the next frame: one frame of latency
              out_word_next = fmt_word;
              out_len_next = fmt_len;
              busy_next = 1'b0;
              state_next = ST_IDLE;
            end
            else
            begin
              conv_cnt_next = conv_cnt_reg + 6'h01;
            end
          end
        end
        ST_PDOWN:
        begin
          // nothing here needs aclk, so it may be stopped until cs falls
          if (cs_fall)
          begin
            pd_next = 1'b0;
            state_next = ST_ARM;
            arm_cnt_next = 2'h0;
            full_seen_next = 1'b0;
          end
        end
        default:
        begin
          state_next = ST_IDLE;
          oe_next = 1'b0;
          busy_next = 1'b0;
          pd_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= ST_IDLE;
      arm_cnt_reg <= 2'h0;
      conv_cnt_reg <= 6'h00;
      full_seen_reg <= 1'b0;
      oe_reg <= 1'b0;
      busy_reg <= 1'b0;
      pd_reg <= 1'b0;
      uni_reg <= 1'b1;
      msbf_reg <= 1'b1;
      wl_reg <= `WL_12;
      out_word_reg <= 16'h0000;
      out_len_reg <= `LEN_12;
    end
    else
    begin
      state_reg <= state_next;
      arm_cnt_reg <= arm_cnt_next;
      conv_cnt_reg <= conv_cnt_next;
      full_seen_reg <= full_seen_next;
      oe_reg <= oe_next;
      busy_reg <= busy_next;
      pd_reg <= pd_next;
      uni_reg <= uni_next;
      msbf_reg <= msbf_next;
      wl_reg <= wl_next;
      out_word_reg <= out_word_next;
      out_len_reg <= out_len_next;
    end
  end

  assign dout_oe_o = oe_reg;
  assign conv_busy_o = busy_reg;
  assign pwr_down_o = pd_reg;
  assign state_o = state_reg;

  // ---------------- link domain (sclk) ----------------
  // a high cs ends the frame on its own, since sclk may stand still then
  logic link_rst_n;
  assign link_rst_n = reset_n_i & ~cs_n_i;

  logic [4:0] rx_cnt_reg;
  logic [4:0] rx_cnt_next;
  logic sample_reg;
  logic sample_next;
  logic cfg_full_next;
  logic [`CFG_W-1:0] cfg_shift_next;
  logic [2:0] pos_reg;
  logic [2:0] pos_next;
  logic [2:0] neg_reg;
  logic [2:0] neg_next;
  logic com_reg;
  logic com_next;

  always_comb
  begin
    rx_cnt_next = rx_cnt_reg;
    sample_next = sample_reg;
    cfg_full_next = cfg_full_reg;
    cfg_shift_next = cfg_shift_reg;
    pos_next = pos_reg;
    neg_next = neg_reg;
    com_next = com_reg;
    if (rx_cnt_reg != `BIT_CNT_MAX)
    begin
      rx_cnt_next = rx_cnt_reg + 5'h01;
    end
    // only the first eight bits count; later ones are ignored
    if (rx_cnt_reg < 5'(`CFG_W))
    begin
      cfg_shift_next = {cfg_shift_reg[`CFG_W-2:0], din_i};
    end
    if (rx_cnt_reg == `CFG_LAST)
    begin
      cfg_full_next = 1'b1;
    end
    // four bits in: cfg_shift[3:0] is mode, odd, select
    if (rx_cnt_reg == `MUX_BITS)
    begin
      pos_next = {cfg_shift_reg[`MUX_SEL_HI:`MUX_SEL_LO],
        cfg_shift_reg[`MUX_ODD_POS]};
      neg_next = {cfg_shift_reg[`MUX_SEL_HI:`MUX_SEL_LO],
        ~cfg_shift_reg[`MUX_ODD_POS]};
      com_next = cfg_shift_reg[`MUX_MODE_POS];
      sample_next = 1'b1;
    end
    if (rx_cnt_reg == `MUX_BITS + `SAMPLE_CYCLES)
    begin
      sample_next = 1'b0;
    end
  end

  always_ff @(posedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rx_cnt_reg <= 5'h00;
      sample_reg <= 1'b0;
      cfg_full_reg <= 1'b0;
    end
    else
    begin
      rx_cnt_reg <= rx_cnt_next;
      sample_reg <= sample_next;
      cfg_full_reg <= cfg_full_next;
    end
  end

  // config and selector survive cs high so the core can read them
  always_ff @(posedge sclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_shift_reg <= 8'h00;
      pos_reg <= 3'h0;
      neg_reg <= 3'h1;
      com_reg <= 1'b0;
    end
    else
    begin
      cfg_shift_reg <= cfg_shift_next;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      com_reg <= com_next;
    end
  end

  assign sample_o = sample_reg;
  assign pos_ch_o = pos_reg;
  assign neg_ch_o = neg_reg;
  assign neg_com_o = com_reg;

  // out_word_reg/out_len_reg only change during conversion, never in a frame
  logic [4:0] tx_cnt_reg;
  logic [4:0] tx_cnt_next;
  logic dout_reg;
  logic dout_next;

  always_comb
  begin
    tx_cnt_next = tx_cnt_reg;
    dout_next = 1'b0;
    if (tx_cnt_reg != `BIT_CNT_MAX)
    begin
      tx_cnt_next = tx_cnt_reg + 5'h01;
    end
    if (tx_cnt_reg < out_len_reg)
    begin
      dout_next = out_word_reg[tx_cnt_reg[3:0]];
    end
  end

  // falling edge launch keeps each bit steady across the host's rising edge
  always_ff @(negedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      tx_cnt_reg <= 5'h00;
      dout_reg <= 1'b0;
    end
    else
    begin
      tx_cnt_reg <= tx_cnt_next;
      dout_reg <= dout_next;
    end
  end

  assign dout_o = dout_reg;

endmodule : adc_port_top

// ---- tb/adc_port_chk.sv ----
// pin level checks of the converter control port, bound to its top module.
// assumes ce_i stays high and aclk_i runs far slower than core_clk_i.
`timescale 1ns/1ns
module adc_port_chk (
  input logic core_clk_i, // core clock
  input logic reset_n_i, // reset, active low
  input logic cs_n_i, // chip select
  input logic aclk_i, // conversion clock
  input logic sclk_i, // shift clock
  input logic din_i, // config data
  input logic dout_oe_o, // output enable
  input logic sample_o, // track window
  input logic [2:0] pos_ch_o, // plus channel
  input logic [2:0] neg_ch_o, // minus channel
  input logic neg_com_o, // minus on common
  input logic conv_busy_o, // converting
  input logic pwr_down_o, // shutdown
  input adc_port_pkg::ctrl_state_t state_o // state
);
  import adc_port_pkg::*;
  logic aclk_reg;
  logic afall;
  logic [1:0] arm_reg;
  logic [5:0] conv_reg;
  logic [4:0] cfg_reg;
  // raw pin edges run ahead of the design's synchronised view
  assign afall = aclk_reg && !aclk_i;
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      aclk_reg <= 1'h0;
      arm_reg <= 2'h0;
      conv_reg <= 6'h00;
    end
    else
    begin
      aclk_reg <= aclk_i;
      arm_reg <= cs_n_i ? 2'h0 : arm_reg + {1'h0, afall && arm_reg != 2'h3};
      conv_reg <= conv_busy_o ? conv_reg + {5'h00, afall} : 6'h00;
    end
  end
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      cfg_reg <= 5'h00;
    else
      cfg_reg <= {cfg_reg[3:0], din_i};
  end
  chk_oe_armed: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $rose(dout_oe_o) |-> arm_reg >= 2'h2) else $error("oe before arming");
  chk_oe_release: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cs_n_i [*5] |-> !dout_oe_o) else $error("oe with cs high");
  chk_conv_len: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $fell(conv_busy_o) |-> conv_reg >= 6'h33 && conv_reg <= 6'h35) else $error("conv length");
  chk_conv_state: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    conv_busy_o |-> state_o == ST_CONV) else $error("busy outside conv");
  chk_conv_start: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $rose(conv_busy_o) |-> $past(cs_n_i) && $past(cs_n_i, 2)) else $error("conv with cs low");
  chk_pd_idle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    pwr_down_o |-> state_o == ST_PDOWN && !conv_busy_o && !dout_oe_o) else $error("pd busy");
  chk_sample_len: assert property (@(posedge sclk_i) disable iff (!reset_n_i || cs_n_i)
    $rose(sample_o) |-> sample_o [*7] ##1 !sample_o) else $error("sample width");
  chk_chan_map: assert property (@(posedge sclk_i) disable iff (!reset_n_i || cs_n_i)
    $rose(sample_o) |-> pos_ch_o == {cfg_reg[2:1], cfg_reg[3]}
    && neg_ch_o == {cfg_reg[2:1], !cfg_reg[3]} && neg_com_o == cfg_reg[4])
    else $error("channel map");
endmodule : adc_port_chk
bind adc_port_top adc_port_chk u_adc_port_chk (.*);

// ---- tb/host_model.sv ----
// host model: chip select, shift clock, config data and conversion clock.
// assumes the bench calls xfer only between frames.
`timescale 1ns/1ns
module host_model (
  input logic core_clk_i, // places the chip select rising edge
  input logic dout_i, // device data
  input logic dout_oe_i, // device output enable
  output logic cs_n_o, // chip select, active low
  output logic sclk_o, // shift clock, still between frames
  output logic din_o, // config data
  output logic aclk_o // conversion clock
);
  logic aclk_run = 1'h1;
  logic pin_last = 1'h0;
  logic pin;
  initial
  begin
    cs_n_o = 1'h1;
    sclk_o = 1'h0;
    din_o = 1'h0;
    aclk_o = 1'h0;
  end
  // a released line shows the inverse of its last level
  assign pin = dout_oe_i ? dout_i : !pin_last;
  always @(posedge sclk_o) pin_last <= pin;
  // edges land on core falling edges; may stop in shutdown
  always
  begin
    #200;
    if (aclk_run)
      aclk_o = !aclk_o;
  end
  task automatic xfer(input logic [7:0] cfg, input bit abort, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge aclk_o);
    cs_n_o = 1'h0;
    if (abort)
      @(negedge aclk_o);
    else
    begin
      repeat (2) @(negedge aclk_o);
      #407;
      for (int i = 0; i <= 16; i++)
      begin
        din_o = (i < 8) ? cfg[7 - i] : !din_o;
        #6 sclk_o = 1'h1;
        if (i > 0)
          rx = {rx[14:0], pin};
        #6 sclk_o = 1'h0;
      end
      @(negedge core_clk_i);
    end
    cs_n_o = 1'h1;
    if (!abort)
      repeat (56) @(negedge aclk_o);
  endtask : xfer
endmodule : host_model

// ---- tb/serial_adc_control_port_tb.sv ----
// self-checking bench for the converter control port with a host model.
// assumes the host model paces chip select and both serial clocks.
`timescale 1ns/1ns
`include "adc_port_cfg.svh"
module serial_adc_control_port_tb;
  import adc_port_pkg::*;
  logic core_clk_i;
  logic reset_n_i;
  logic cs_n_i;
  logic aclk_i;
  logic sclk_i;
  logic din_i;
  logic [`RES_W-1:0] raw_code_i;
  logic dout_o, dout_oe_o, sample_o, neg_com_o, conv_busy_o, pwr_down_o;
  logic [2:0] pos_ch_o, neg_ch_o;
  ctrl_state_t state_o;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] prev_cfg = 8'h0C;
  logic [11:0] prev_raw = 12'h000;
  // covers both modes, all selects, polarities, bit orders and lengths
  logic [7:0] cfg_tab [8] = '{8'h8C, 8'h51, 8'hEA, 8'h36, 8'h95, 8'h7C, 8'hF0, 8'h09};
  logic [11:0] raw_tab [8] = '{12'hA5C, 12'h3E1, 12'h800, 12'h7FF, 12'hFFF, 12'h001,
    12'h9C3, 12'h6B4};
  adc_port_top u_adc_port_top (.ce_i(1'h1), .*);
  host_model u_host_model (
    .core_clk_i(core_clk_i),
    .dout_i(dout_o),
    .dout_oe_i(dout_oe_o),
    .cs_n_o(cs_n_i),
    .sclk_o(sclk_i),
    .din_o(din_i),
    .aclk_o(aclk_i)
  );
  initial
  begin
    core_clk_i = 1'h0;
    forever #25 core_clk_i = !core_clk_i;
  end
  // eleven frames of about 500 cycles each and one short abort frame
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t word %h exp %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk_flag
  // stream as shifted, first bit at the top, padding zeros after the word
  function automatic logic [15:0] exp_word(input logic [7:0] c, input logic [11:0] raw);
    logic [11:0] code;
    logic [15:0] w;
    int len;
    code = c[`CFG_POL_BIT] ? raw : {!raw[11], raw[10:0]};
    len = (c[1:0] == `WL_8) ? 8 : 12;
    w = 16'h0000;
    for (int i = 0; i < len; i++)
      w[15 - i] = c[`CFG_MSBF_BIT] ? code[11 - i] : code[i];
    return w;
  endfunction : exp_word
  task automatic run_frame(input logic [7:0] c, input logic [11:0] raw, input bit cmp);
    logic [15:0] rx;
    raw_code_i = raw;
    u_host_model.xfer(c, 1'h0, rx);
    if (cmp)
      chk_word(rx, exp_word(prev_cfg, prev_raw));
    prev_cfg = c;
    prev_raw = raw;
    chk_flag(conv_busy_o, 1'h0, "busy");
    $display("frame %h done", c);
  endtask : run_frame
  task automatic abort_frame();
    logic [15:0] rx;
    u_host_model.xfer(8'h8C, 1'h1, rx);
    repeat (10) @(negedge core_clk_i);
    chk_flag(conv_busy_o, 1'h0, "abort busy");
    chk_flag(state_o === ST_IDLE, 1'h1, "abort state");
    $display("abort done");
  endtask : abort_frame
  initial
  begin
    reset_n_i = 1'h0;
    raw_code_i = 12'h000;
    repeat (5) @(posedge core_clk_i);
    @(negedge core_clk_i);
    reset_n_i = 1'h1;
    chk_flag(dout_oe_o, 1'h0, "reset oe");
    chk_flag(state_o === ST_IDLE, 1'h1, "reset state");
    for (int k = 0; k < 8; k++)
    begin
      run_frame(cfg_tab[k], raw_tab[k], 1'h1);
      if (k == 3)
        abort_frame();
    end
    run_frame(8'h2B, 12'h5A5, 1'h1);
    chk_flag(pwr_down_o, 1'h1, "pd set");
    chk_flag(state_o === ST_PDOWN, 1'h1, "pd state");
    u_host_model.aclk_run = 1'h0;
    repeat (101) @(negedge core_clk_i);
    u_host_model.aclk_run = 1'h1;
    run_frame(8'hEA, 12'h5A5, 1'h0);
    chk_flag(pwr_down_o, 1'h0, "pd clear");
    run_frame(8'h0C, 12'h000, 1'h1);
    finish_test();
  end
endmodule : serial_adc_control_port_tb
